// file: verilog/arf_pkg.sv
// Purpose: Shared constants and carriers for the converter result formatter.
// Assumes: 8-bit register port, one clock, asynchronous active-high reset.
// Notes:   Offsets are byte indices on the plain register port.
package arf_pkg;

  // Register offsets.
  localparam logic [7:0] ARF_OFS_SECOND_CTL  = 8'h03;
  localparam logic [7:0] ARF_OFS_RESULT_LOW  = 8'h04;
  localparam logic [7:0] ARF_OFS_RESULT_HIGH = 8'h05;
  localparam logic [7:0] ARF_OFS_STATUS      = 8'h06;
  localparam logic [7:0] ARF_OFS_CHAN_REF    = 8'h07;

  // Field positions.
  localparam int ARF_BIT_BIPOLAR   = 7;
  localparam int ARF_BIT_DONE      = 0;
  localparam int ARF_BIT_TEMP_EN   = 1;
  localparam int ARF_BIT_GAIN      = 0;
  localparam int ARF_REF_MSB       = 7;
  localparam int ARF_REF_LSB       = 6;
  localparam int ARF_CHAN_MSB      = 5;

  // Reset values.
  localparam logic [7:0] ARF_RST_CHAN_REF   = 8'h00;
  localparam logic       ARF_RST_BIPOLAR    = 1'b0;

  // Channel and reference codes.
  localparam logic [5:0] ARF_CHAN_TEMP      = 6'h22;
  localparam logic [5:0] ARF_CHAN_DIFF_LO   = 6'h08;
  localparam logic [5:0] ARF_CHAN_DIFF_HI   = 6'h1f;
  localparam logic [5:0] ARF_CHAN_REV_LO    = 6'h23;
  localparam logic [1:0] ARF_REF_INT_1V1    = 2'h2;

  // Coding limits and gain.
  localparam int ARF_CODE_W        = 10;
  localparam int ARF_WIDE_W        = 17;
  localparam logic signed [16:0] ARF_UNI_MAX = 17'sh003ff;
  localparam logic signed [16:0] ARF_BIP_MAX = 17'sh001ff;
  localparam logic signed [16:0] ARF_BIP_MIN = -17'sh00200;
  localparam logic signed [16:0] ARF_GAIN_HI = 17'sh00014;

  // Formatting mode handed to the coder.
  typedef struct packed {
    logic diff_mode;
    logic bipolar;
    logic gain_hi;
  } arf_mode_s;

  // A finished, coded result.
  typedef struct packed {
    logic                  valid;
    logic [9:0]            code;
  } arf_result_s;

endpackage

// file: verilog/arf_result_coder.sv
// Purpose: Apply gain, clamp and code one raw converter sample.
// Assumes: Sample is signed, one step equal to the reference over 1024.
// Notes:   One cycle from sample strobe to coded result.
`timescale 1ns/1ps
module arf_result_coder import arf_pkg::*; #(
  parameter int SAMPLE_W = 12
) (
  // Clock and reset.
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  // Raw sample in.
  input  wire logic                 smp_valid,
  input  wire logic [SAMPLE_W-1:0]  smp_data,
  input  wire arf_mode_s            mode,
  // Coded result out.
  output arf_result_s               res_ff
);

  // Gain times twelve bits must stay inside the wide path.
  if (SAMPLE_W < 11 || SAMPLE_W > 12) begin : g_bad_sample_w
    $error("arf_result_coder: SAMPLE_W must be 11 or 12");
  end

  logic signed [ARF_WIDE_W-1:0] wide;
  logic signed [ARF_WIDE_W-1:0] half;
  logic [9:0]                   nxt_code;

  // Gain applies only to differential pairs; single-ended is always 1x.
  always_comb begin
    wide = ARF_WIDE_W'($signed(smp_data));
    if (mode.diff_mode && mode.gain_hi) begin
      wide = ARF_WIDE_W'(wide * ARF_GAIN_HI);
    end
    half = wide >>> 1;
    if (mode.diff_mode && mode.bipolar) begin
      // Halving gives the 512-step scale; saturate to the signed range.
      if (half > ARF_BIP_MAX) begin
        nxt_code = ARF_BIP_MAX[9:0];
      end else if (half < ARF_BIP_MIN) begin
        nxt_code = ARF_BIP_MIN[9:0];
      end else begin
        nxt_code = half[9:0];
      end
    end else if (wide < 0) begin
      nxt_code = 10'h000;
    end else if (wide > ARF_UNI_MAX) begin
      nxt_code = ARF_UNI_MAX[9:0];
    end else begin
      nxt_code = wide[9:0];
    end
  end

  // Registered result so the top sees a clean strobe.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      res_ff <= '0;
    end else begin
      res_ff.valid <= smp_valid;
      if (smp_valid) begin
        res_ff.code <= nxt_code;
      end
    end
  end

endmodule

// file: verilog/arf_result_format.sv
// Summary of operation
// - After conversion-done is set, result is readable as low and high bytes.
// - Single-ended result is unsigned 10-bit, input times 1024 over reference.
// - Unipolar differential result is unsigned, clamped to zero when negative input larger.
// - Bipolar differential result is two's complement, difference times 512 over reference.
// - Top result bit in high byte is the sign in bipolar mode.
// - Unipolar after reset; bipolar-select bit written one selects bipolar.
// - Differential difference is multiplied by gain 1x or 20x before coding.
// - Channel code 100010 selects the temperature sensor single-ended and enables it.
// - Each completed conversion writes the result bytes and sets conversion-done.
// - Reference field value binary 10 selects the internal 1.1V reference.
// - On differential channels the lowest channel bit picks gain, 0 is 1x.
//
// Purpose: Register front end and result presentation for a 10-bit converter.
// Assumes: Analog side gives a signed sample with a one-cycle done strobe.
// Notes:   Read data appear in the cycle after the read strobe only.
//          Byte map: 0x03 second control (bit 7 bipolar select), 0x04 result low,
//          0x05 result high, 0x06 status (bit 0 done, write one clears; bit 1
//          sensor enabled, read only), 0x07 channel and reference.
//          Settings are not locked during a conversion; the coder samples them
//          on the done strobe, so software should leave them alone until then.
//          Every analog-side output is a register and lags its write by a cycle.
//
// The strobed register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module arf_result_format import arf_pkg::*; #(
  parameter int SAMPLE_W = 12
) (
  // Clock and reset.
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  // Register port.
  input  wire logic [7:0]           reg_addr,
  input  wire logic [7:0]           reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic [7:0]                reg_rdata_ff,
  // Converter side.
  input  wire logic                 conv_done,
  input  wire logic [SAMPLE_W-1:0]  conv_sample,
  output logic [5:0]                chan_sel_ff,
  output logic [1:0]                ref_sel_ff,
  output logic                      ref_int_1v1_ff,
  output logic                      temp_sensor_en_ff,
  output logic                      diff_mode_ff,
  output logic                      gain_hi_ff,
  output logic                      conversion_done_flag_ff
);

  // Differential decode is used for the coder mode and the analog outputs.
  // Codes 08..1f are the normal pairs and 23 upwards the reversed and offset
  // pairs; 20..22 are ground, the band gap and the sensor, all single-ended.
  function automatic logic is_diff(input logic [5:0] ch);
    is_diff = (ch >= ARF_CHAN_DIFF_LO && ch <= ARF_CHAN_DIFF_HI) || (ch >= ARF_CHAN_REV_LO);
  endfunction

  logic [7:0]   channel_reference_register_ff;
  logic         bipolar_select_ff;
  logic [7:0]   result_low_byte_ff;
  logic [7:0]   result_high_byte_ff;
  logic [7:0]   second_ctl_byte;
  logic [7:0]   status_byte;
  logic [7:0]   nxt_rdata;
  arf_mode_s    mode;
  arf_result_s  coded;
  logic         clr_done;

  // Eleven bits hold a full single-ended code with its sign, and the coder's
  // wide path is sized for twelve; anything else cannot be served.
  if (SAMPLE_W < 11 || SAMPLE_W > 12) begin : g_bad_sample_w
    $error("arf_result_format: SAMPLE_W must be 11 or 12");
  end

  // Writing one to the done bit clears the flag; writing zero leaves it, so a
  // read-modify-write of the status byte cannot drop a fresh result.
  assign clr_done = reg_wr && reg_addr == ARF_OFS_STATUS && reg_wdata[ARF_BIT_DONE];

  // The coder sees live settings; it only samples them on a done strobe.
  // Software that rewrites them mid-conversion gets whichever is current then.
  assign mode.diff_mode = is_diff(channel_reference_register_ff[ARF_CHAN_MSB:0]);
  assign mode.bipolar   = bipolar_select_ff;
  assign mode.gain_hi   = channel_reference_register_ff[ARF_BIT_GAIN];

  // Gain, clamp and coding; the coded result follows the strobe by one cycle,
  // which keeps the multiplier out of the register update path.
  arf_result_coder #(
    .SAMPLE_W (SAMPLE_W)
  ) u_coder (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .smp_valid (conv_done),
    .smp_data  (conv_sample),
    .mode      (mode),
    .res_ff    (coded)
  );

  // Channel and reference register; every bit is software read/write and
  // takes effect on the write edge.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      channel_reference_register_ff <= ARF_RST_CHAN_REF;
    end else if (reg_wr && reg_addr == ARF_OFS_CHAN_REF) begin
      channel_reference_register_ff <= reg_wdata;
    end
  end

  // Bipolar select; unipolar until software asks otherwise. Single-ended
  // channels ignore it and always code unsigned.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bipolar_select_ff <= ARF_RST_BIPOLAR;
    end else if (reg_wr && reg_addr == ARF_OFS_SECOND_CTL) begin
      bipolar_select_ff <= reg_wdata[ARF_BIT_BIPOLAR];
    end
  end

  // Result bytes load together so a reader never sees a torn pair.
  // The top six bits of the high byte read zero in every mode.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      result_low_byte_ff  <= 8'h00;
      result_high_byte_ff <= 8'h00;
    end else if (coded.valid) begin
      result_low_byte_ff  <= coded.code[7:0];
      result_high_byte_ff <= {6'h00, coded.code[9:8]};
    end
  end

  // Done flag; a new result in the clearing cycle keeps it set, since losing
  // a completion is worse than reporting one twice.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      conversion_done_flag_ff <= 1'b0;
    end else if (coded.valid) begin
      conversion_done_flag_ff <= 1'b1;
    end else if (clr_done) begin
      conversion_done_flag_ff <= 1'b0;
    end
  end

  // Channel field towards the input multiplexer; registered so it settles
  // before the converter samples it.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      chan_sel_ff <= 6'h00;
    end else begin
      chan_sel_ff <= channel_reference_register_ff[ARF_CHAN_MSB:0];
    end
  end

  // Differential and gain flags, so the input stage and the coder agree.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      diff_mode_ff <= 1'b0;
      gain_hi_ff   <= 1'b0;
    end else begin
      diff_mode_ff <= mode.diff_mode;
      gain_hi_ff   <= mode.diff_mode && mode.gain_hi;
    end
  end

  // Reference field and its internal 1.1V decode.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ref_sel_ff     <= 2'h0;
      ref_int_1v1_ff <= 1'b0;
    end else begin
      ref_sel_ff     <= channel_reference_register_ff[ARF_REF_MSB:ARF_REF_LSB];
      ref_int_1v1_ff <= channel_reference_register_ff[ARF_REF_MSB:ARF_REF_LSB]
                        == ARF_REF_INT_1V1;
    end
  end

  // Sensor enable; only the sensor code switches it on, so it idles whenever
  // an ordinary channel is selected.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      temp_sensor_en_ff <= 1'b0;
    end else begin
      temp_sensor_en_ff <= channel_reference_register_ff[ARF_CHAN_MSB:0]
                           == ARF_CHAN_TEMP;
    end
  end

  // Composite bytes; unused bits read zero so software can test a field
  // without masking, and field positions come from one place.
  always_comb begin
    second_ctl_byte                  = 8'h00;
    second_ctl_byte[ARF_BIT_BIPOLAR] = bipolar_select_ff;
    status_byte                      = 8'h00;
    status_byte[ARF_BIT_DONE]        = conversion_done_flag_ff;
    status_byte[ARF_BIT_TEMP_EN]     = temp_sensor_en_ff;
  end

  // Read mux; unmapped offsets read zero and writes to them are dropped.
  // Result bytes are read only; writes to them are ignored.
  always_comb begin
    unique case (reg_addr)
      ARF_OFS_SECOND_CTL:  nxt_rdata = second_ctl_byte;
      ARF_OFS_RESULT_LOW:  nxt_rdata = result_low_byte_ff;
      ARF_OFS_RESULT_HIGH: nxt_rdata = result_high_byte_ff;
      ARF_OFS_STATUS:      nxt_rdata = status_byte;
      ARF_OFS_CHAN_REF:    nxt_rdata = channel_reference_register_ff;
      default:             nxt_rdata = 8'h00;
    endcase
  end

  // Read data stand for exactly the cycle after the strobe.
  // Zero outside that cycle, so an idle port shows nothing stale.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata_ff <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata_ff <= nxt_rdata;
    end else begin
      reg_rdata_ff <= 8'h00;
    end
  end

endmodule

// file: test/arf_result_format_chk.sv
// Purpose: Port checks for the result formatter.
// Assumes: One clock, asynchronous active-high reset.
// Notes:   Bound into every formatter instance.
`timescale 1ns/1ps
module arf_result_format_chk import arf_pkg::*; (
  // Clock and reset.
  input wire logic       clk,
  input wire logic       sys_rst,
  // Register port.
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata_ff,
  // Converter side.
  input wire logic       conv_done,
  input wire logic [5:0] chan_sel_ff,
  input wire logic [1:0] ref_sel_ff,
  input wire logic       ref_int_1v1_ff,
  input wire logic       temp_sensor_en_ff,
  input wire logic       diff_mode_ff,
  input wire logic       gain_hi_ff,
  input wire logic       conversion_done_flag_ff
);
  // One domain, so clock and reset are given once.
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_done_sets_flag: assert property (conv_done |-> ##2 conversion_done_flag_ff)
    else $error("done flag late");
  a_flag_sticky: assert property (conversion_done_flag_ff
    && !(reg_wr && reg_addr == ARF_OFS_STATUS && reg_wdata[ARF_BIT_DONE])
    |=> conversion_done_flag_ff) else $error("done flag lost");
  a_temp_decode: assert property (temp_sensor_en_ff == (chan_sel_ff == ARF_CHAN_TEMP))
    else $error("sensor enable wrong");
  a_ref_decode: assert property (ref_int_1v1_ff == (ref_sel_ff == ARF_REF_INT_1V1))
    else $error("reference decode wrong");
  a_gain_decode: assert property (gain_hi_ff == (diff_mode_ff && chan_sel_ff[0]))
    else $error("gain decode wrong");
  a_diff_decode: assert property (diff_mode_ff == (chan_sel_ff >= ARF_CHAN_REV_LO
    || chan_sel_ff inside {[ARF_CHAN_DIFF_LO:ARF_CHAN_DIFF_HI]})) else $error("diff decode");
  a_chan_write: assert property (reg_wr && reg_addr == ARF_OFS_CHAN_REF
    |-> ##2 {ref_sel_ff, chan_sel_ff} == $past(reg_wdata, 2)) else $error("channel write lost");
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata_ff == 8'h00)
    else $error("read data outside read");
  a_high_pad: assert property (reg_rd && reg_addr == ARF_OFS_RESULT_HIGH
    |=> reg_rdata_ff[7:2] == 6'h00) else $error("high byte pad");
  // Main scenarios seen at least once.
  c_diff_conv: cover property (conv_done && diff_mode_ff);
  c_temp_ref: cover property (temp_sensor_en_ff && ref_int_1v1_ff);
  c_high_read: cover property (reg_rd && reg_addr == ARF_OFS_RESULT_HIGH);
endmodule
bind arf_result_format arf_result_format_chk arf_result_format_chk_i (
  .clk                     (clk),
  .sys_rst                 (sys_rst),
  .reg_addr                (reg_addr),
  .reg_wdata               (reg_wdata),
  .reg_wr                  (reg_wr),
  .reg_rd                  (reg_rd),
  .reg_rdata_ff            (reg_rdata_ff),
  .conv_done               (conv_done),
  .chan_sel_ff             (chan_sel_ff),
  .ref_sel_ff              (ref_sel_ff),
  .ref_int_1v1_ff          (ref_int_1v1_ff),
  .temp_sensor_en_ff       (temp_sensor_en_ff),
  .diff_mode_ff            (diff_mode_ff),
  .gain_hi_ff              (gain_hi_ff),
  .conversion_done_flag_ff (conversion_done_flag_ff)
);

// file: test/arf_analog_src.sv
// Purpose: Behavioural analog inputs and temperature sensor.
// Assumes: Samples are pre-gain, one step per reference over 1024.
// Notes:   Sample lines change outside a conversion.
`timescale 1ns/1ps
module arf_analog_src #(
  parameter int SAMPLE_W = 12,
  parameter int TEMP_LSB = 300
) (
  // Clock and sensor enable.
  input  wire logic           clk,
  input  wire logic           temp_en,
  // Conversion out.
  output logic                conv_done,
  output logic [SAMPLE_W-1:0] conv_sample
);
  // Idle at time zero.
  initial begin
    conv_done = 1'b0;
    conv_sample = '0;
  end
  // The sensor replaces the pin value only while it is enabled.
  task automatic convert(input logic [SAMPLE_W-1:0] v);
    @(posedge clk);
    conv_done <= 1'b1;
    conv_sample <= temp_en ? SAMPLE_W'(TEMP_LSB) : v;
    @(posedge clk);
    conv_done <= 1'b0;
    conv_sample <= ~v; // A stale value would hide a late capture.
  endtask
endmodule

// file: test/arf_result_format_tb_top.sv
// Purpose: Self-checking bench for the result formatter.
// Assumes: Sample width 12, sensor reading 300.
// Notes:   Expected codes come from the local code_of model, except the sensor code 0x12c in t_temp.
`timescale 1ns/1ps
module arf_result_format_tb_top import arf_pkg::*;;
  logic       clk, sys_rst, reg_wr, reg_rd, conv_done, ref_1v1, temp_en, diff, gain, done;
  logic [7:0] reg_addr, reg_wdata, rdata, d;
  logic [11:0] smp;
  logic [5:0] chan;
  logic [1:0] refs;
  int         miscompares, n_tests;
  arf_result_format #(.SAMPLE_W(12)) arf_result_format_i (.clk(clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_ff(rdata), .conv_done(conv_done), .conv_sample(smp), .chan_sel_ff(chan),
    .ref_sel_ff(refs), .ref_int_1v1_ff(ref_1v1), .temp_sensor_en_ff(temp_en),
    .diff_mode_ff(diff), .gain_hi_ff(gain), .conversion_done_flag_ff(done));
  arf_analog_src #(.SAMPLE_W(12)) arf_analog_src_i (.clk(clk), .temp_en(temp_en),
    .conv_done(conv_done), .conv_sample(smp));
  // Clock at 40 MHz.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Register bus cycles; the read returns the byte from the cycle after the strobe.
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = rdata;
  endtask
  // Reference coder: gain, halving for bipolar, then saturation.
  function automatic logic [9:0] code_of(int s, bit bip, int g);
    int v;
    v = bip ? (s * g) >>> 1 : s * g;
    if (bip) v = (v > 511) ? 511 : (v < -512) ? -512 : v;
    else v = (v > 1023) ? 1023 : (v < 0) ? 0 : v;
    return v[9:0];
  endfunction
  // One conversion, then flag and both result bytes are judged.
  task automatic conv(input int s, input logic [9:0] exp);
    logic [7:0] lo;
    int k;
    wr(ARF_OFS_STATUS, 8'h01);
    arf_analog_src_i.convert(s[11:0]);
    k = 0;
    #1;
    check("cleared", 16'(done), 16'h0000);
    while (done !== 1'b1 && k < 8) begin
      @(posedge clk);
      #1 k++;
    end
    if (done !== 1'b1) begin
      miscompares++;
      end_sim();
    end else begin
      rd(ARF_OFS_STATUS);
      check("flag", 16'(d[0]), 16'h0001);
      rd(ARF_OFS_RESULT_LOW);
      lo = d;
      rd(ARF_OFS_RESULT_HIGH);
      check("result", {d, lo}, {6'h00, exp});
    end
  endtask
  task automatic run_set(input logic [5:0] ch, input bit bip, input int g, input int s[4]);
    wr(ARF_OFS_CHAN_REF, {2'b00, ch});
    wr(ARF_OFS_SECOND_CTL, {bip, 7'h00});
    check("gain", 16'(gain), 16'(g == 20));
    check("diff", 16'(diff), 16'(ch != 6'h00));
    foreach (s[i]) conv(s[i], code_of(s[i], bip, g));
  endtask
  task automatic t_reset();
    check("outs", {refs, chan, ref_1v1, temp_en, diff, gain, done}, 16'h0000);
    rd(ARF_OFS_SECOND_CTL);
    check("second", 16'(d), 16'h0000);
    rd(8'h10);
    check("unmapped", 16'(d), 16'h0000);
    $display("t_reset done");
  endtask
  task automatic t_formats();
    run_set(6'h00, 1'b0, 1, '{0, 1, 512, 1023});
    run_set(ARF_CHAN_DIFF_LO, 1'b0, 1, '{-5, 0, 700, 1023});
    run_set(6'h09, 1'b0, 20, '{30, 100, -1, 51});
    run_set(ARF_CHAN_DIFF_LO, 1'b1, 1, '{-100, 1023, -1024, -1});
    run_set(6'h09, 1'b1, 20, '{10, -60, 60, -2});
    run_set(6'h28, 1'b1, 1, '{-3, 7, 0, -512});
    run_set(6'h28, 1'b0, 1, '{-3, 7, 0, 1});
    $display("t_formats done");
  endtask
  task automatic t_temp();
    wr(ARF_OFS_CHAN_REF, {ARF_REF_INT_1V1, ARF_CHAN_TEMP});
    wr(ARF_OFS_SECOND_CTL, 8'h80);
    check("temp outs", {ref_1v1, temp_en, diff, gain}, 16'h000c);
    check("temp sel", {refs, chan}, {ARF_REF_INT_1V1, ARF_CHAN_TEMP});
    rd(ARF_OFS_STATUS);
    check("temp stat", 16'(d[ARF_BIT_TEMP_EN]), 16'h0001);
    conv(5, 10'h12c);
    $display("t_temp done");
  endtask
  // Inputs idle under reset; traffic starts at the first edge after release.
  initial begin
    sys_rst = 1'b1;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    t_reset();
    t_formats();
    t_temp();
    end_sim();
  end
endmodule
